// ===== sfo_defs.svh
// Offsets, field positions, reset values and counts of the fanout config
`ifndef SFO_DEFS_SVH
`define SFO_DEFS_SVH

`define SFO_CFG_BITS      10
`define SFO_OUT_COUNT     8
`define SFO_SYNC_STAGES   3

`define SFO_ADDR_W        4
`define SFO_CTRL_OFS      4'h0
`define SFO_STATUS_OFS    4'h4
`define SFO_CONFIG_OFS    4'h8
`define SFO_OUTSTAT_OFS   4'hc

`define SFO_CTRL_SOFT_EN  0
`define SFO_ST_CONFIGURED 0
`define SFO_ST_OE_PIN     1
`define SFO_ST_LATCH_PIN  2
`define SFO_OS_TYPE_LSB   8

`define SFO_CTRL_RST      1'b1
`define SFO_CFG_RST       10'h000

`endif

// ===== sfo_pkg.sv
// Types shared by the fanout configuration logic
package sfo_pkg;

	// Bit order follows the shift order: first bit shifted lands on top
	typedef struct packed {
		logic [7:0] outEnable;        // out_d1 at [7] ... out_a0 at [0]
		logic       banksBcdTypeBit;  // Low LVDS, high LVPECL
		logic       bankATypeBit;     // Low LVDS, high LVPECL
	} sfo_cfg_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} sfo_bus_req_t;

	typedef struct packed {
		logic [7:0] outEnable;        // Effective, after the global gate
		logic [7:0] outTypeSel;       // Per output, high means LVPECL
	} sfo_out_t;

endpackage

// ===== sfo_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfo_sync #(
	parameter int         WIDTH     = 1,
	parameter logic [0:0] RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Asynchronous level in, filtered level out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire  [WIDTH-1:0] next_syncOut = (agree & stage3) | (~agree & syncOut);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1  <= {WIDTH{RESET_VAL}};
			stage2  <= {WIDTH{RESET_VAL}};
			stage3  <= {WIDTH{RESET_VAL}};
			syncOut <= {WIDTH{RESET_VAL}};
		end else begin
			stage1  <= asyncIn;
			stage2  <= stage1;
			stage3  <= stage2;
			syncOut <= next_syncOut;
		end
	end
endmodule

// ===== sfo_config.sv
// Serial configuration port and output control of the 1-to-8 fanout
`timescale 1ns/1ps
`include "sfo_defs.svh"
module sfo_config (
	// System clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Register bus, Avalon-MM slave
	input  sfo_pkg::sfo_bus_req_t  busReq,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// Serial configuration link, runs on its own clock
	input  wire logic              serialClk,
	input  wire logic              serial_config_in,
	input  wire logic              latch_strobe,
	output logic                   readbackOut,
	// Global output enable pin
	input  wire logic              globalOutEnable,
	// Output control toward the clock path
	output sfo_pkg::sfo_out_t      outCtl
);
	import sfo_pkg::*;

	// Link domain: reset crossing and shift register
	logic                      linkRst1;
	logic                      linkRst_n;
	logic [`SFO_CFG_BITS-1:0]  shiftWord;

	wire [`SFO_CFG_BITS-1:0] next_shiftWord =
		{shiftWord[`SFO_CFG_BITS-2:0], serial_config_in};

	// Reset needs a few serial clock edges to reach this domain
	always_ff @(posedge serialClk) begin
		linkRst1  <= rst_n;
		linkRst_n <= linkRst1;
	end

	// Shift only while strobe is low, so the word is frozen when latched
	always_ff @(posedge serialClk) begin
		if (!linkRst_n)
			shiftWord <= `SFO_CFG_RST;
		else if (!latch_strobe)
			shiftWord <= next_shiftWord;
	end

	// Top bit is the oldest one: reading the old word while writing anew
	assign readbackOut = shiftWord[`SFO_CFG_BITS-1];

	// System domain: pin synchronisers
	logic oeSync;
	logic leSync;
	logic lePrev;

	// Reset value low stands in for the pin's pull-down
	sfo_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_oe_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (globalOutEnable),
		.syncOut (oeSync)
	);

	sfo_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_le_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (latch_strobe),
		.syncOut (leSync)
	);

	wire leRise = leSync & ~lePrev;

	// Active settings
	sfo_cfg_t cfgActive;
	logic     configured;
	logic     softEnable;

	// Shift word is quasi-static here: the strobe itself stopped the shifter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lePrev     <= 1'b0;
			cfgActive  <= `SFO_CFG_RST;
			configured <= 1'b0;
		end else begin
			lePrev <= leSync;
			if (leRise) begin
				cfgActive  <= shiftWord;
				configured <= 1'b1;
			end
		end
	end

	// Output gating; global pin wins over every loaded enable bit, type bits pass ungated
	wire        gateOn       = oeSync & softEnable;
	wire [7:0]  next_enable  = cfgActive.outEnable & {8{gateOn}};
	wire [7:0]  next_typeSel = {{6{cfgActive.banksBcdTypeBit}},
		{2{cfgActive.bankATypeBit}}};

	always_ff @(posedge clk) begin
		if (!rst_n)
			outCtl <= '0;
		else begin
			outCtl.outEnable  <= next_enable;
			outCtl.outTypeSel <= next_typeSel;
		end
	end

	// Register bus slave, one wait state on every access
	logic ack;

	wire reqActive = busReq.read | busReq.write;
	wire hitCtrl   = busReq.address == `SFO_CTRL_OFS;
	wire hitStatus = busReq.address == `SFO_STATUS_OFS;
	wire hitConfig = busReq.address == `SFO_CONFIG_OFS;
	wire hitOutSt  = busReq.address == `SFO_OUTSTAT_OFS;

	wire [31:0] ctrlWord   = {31'h0, softEnable};
	wire [31:0] statusWord = {29'h0, leSync, oeSync, configured};
	wire [31:0] configWord = {22'h0, cfgActive};
	wire [31:0] outStWord  = {16'h0, outCtl.outTypeSel, outCtl.outEnable};

	// Unmapped offsets read as zero and ignore writes
	wire [31:0] next_readdata =
		({32{hitCtrl}}   & ctrlWord)   |
		({32{hitStatus}} & statusWord) |
		({32{hitConfig}} & configWord) |
		({32{hitOutSt}}  & outStWord);

	wire ctrlWrite = busReq.write & ack & hitCtrl & busReq.byteenable[0];

	assign waitrequest = reqActive & ~ack;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack      <= 1'b0;
			readdata <= 32'h0;
		end else begin
			ack <= reqActive & ~ack;
			if (busReq.read & ~ack)
				readdata <= next_readdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			softEnable <= `SFO_CTRL_RST;
		else if (ctrlWrite)
			softEnable <= busReq.writedata[`SFO_CTRL_SOFT_EN];
	end

	// Checks in the system domain
	a_oe_low_off: assert property (@(posedge clk) disable iff (!rst_n)
		!oeSync |=> outCtl.outEnable == 8'h00)
		else $error("outputs enabled while global enable low");

	a_oe_high_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(oeSync && softEnable && $stable(cfgActive))
		|=> outCtl.outEnable == $past(cfgActive.outEnable))
		else $error("outputs do not follow their enable bits");

	a_oe_overrides: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(oeSync) |=> outCtl.outEnable == 8'h00 [*2])
		else $error("loaded settings beat the global enable");

	a_start_lvds: assert property (@(posedge clk) disable iff (!rst_n)
		!configured |=> (outCtl.outTypeSel == 8'h00 &&
		outCtl.outEnable == 8'h00))
		else $error("unconfigured part not static LVDS");

	a_type_map: assert property (@(posedge clk) disable iff (!rst_n)
		configured |=> (outCtl.outTypeSel[1:0] ==
		{2{$past(cfgActive.bankATypeBit)}} &&
		outCtl.outTypeSel[7:2] ==
		{6{$past(cfgActive.banksBcdTypeBit)}}))
		else $error("bank type selection wrong");

	a_latch_load: assert property (@(posedge clk) disable iff (!rst_n)
		leRise |=> (cfgActive == $past(shiftWord) && configured))
		else $error("latched word not taken");

	a_hold_prev: assert property (@(posedge clk) disable iff (!rst_n)
		!leRise |=> $stable(cfgActive))
		else $error("active settings moved without a latch");

	a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
		(reqActive && waitrequest) |=> !waitrequest)
		else $error("bus answer not in one wait state");

	// Checks in the link domain
	a_shift_in: assert property (@(posedge serialClk) disable iff (!linkRst_n)
		!latch_strobe |=> shiftWord[0] == $past(serial_config_in))
		else $error("serial bit not sampled");

	a_shift_freeze: assert property (@(posedge serialClk)
		disable iff (!linkRst_n)
		latch_strobe |=> $stable(shiftWord))
		else $error("shift word moved while strobe high");

	a_readback: assert property (@(posedge serialClk) disable iff (!linkRst_n)
		(!latch_strobe ##1 !latch_strobe)
		|=> readbackOut == $past(shiftWord[`SFO_CFG_BITS-3], 2))
		else $error("readback does not advance one bit per clock");

endmodule

// ===== sfo_host_model.sv
// Host controller model driving the serial configuration port
`timescale 1ns/1ps
module sfo_host_model (
	// Serial link toward the device
	output logic      serialClk,
	output logic      serial_config_in,
	output logic      latch_strobe,
	input  wire logic readbackOut
);
	// Pulled-down pins idle low
	initial begin
		serialClk = 1'b0;
		serial_config_in = 1'b0;
		latch_strobe = 1'b0;
	end

	// Clock stands still between frames; data moves only after a fall
	task automatic pulse(input logic d);
		serial_config_in = d;
		#40 serialClk = 1'b1;
		#40 serialClk = 1'b0;
	endtask

	// Whole word, top bit first, old word read back meanwhile
	task automatic shift(input logic [9:0] w, output logic [9:0] rb);
		latch_strobe = 1'b0;
		#40;
		for (int i = 9; i >= 0; i--) begin
			rb[i] = readbackOut;
			pulse(w[i]);
		end
		serial_config_in = 1'b0;
	endtask

	// Strobe left high until the next frame
	task automatic latch();
		#40 latch_strobe = 1'b1;
	endtask
endmodule

// ===== sfo_config_tb_top.sv
// Self-checking bench for the fanout configuration block
`timescale 1ns/1ps
module sfo_config_tb_top;
	import sfo_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         globalOutEnable = 1'b0;
	sfo_bus_req_t busReq = '0;
	logic [31:0]  readdata;
	logic         waitrequest;
	logic         serialClk;
	logic         serial_config_in;
	logic         latch_strobe;
	logic         readbackOut;
	sfo_out_t     outCtl;
	int           failures = 0;
	int           tests_run = 0;
	logic [31:0]  q;
	logic [9:0]   rb;
	logic [9:0]   act = '0;
	logic [9:0]   words [5] = '{10'h2a9, 10'h156, 10'h004, 10'h200, 10'h3ff};

	always #2 clk = ~clk;

	sfo_config sfo_config_inst (.clk(clk), .rst_n(rst_n), .busReq(busReq),
		.readdata(readdata), .waitrequest(waitrequest),
		.serialClk(serialClk), .serial_config_in(serial_config_in),
		.latch_strobe(latch_strobe), .readbackOut(readbackOut),
		.globalOutEnable(globalOutEnable), .outCtl(outCtl));

	sfo_host_model sfo_host_model_inst (.serialClk(serialClk),
		.serial_config_in(serial_config_in), .latch_strobe(latch_strobe),
		.readbackOut(readbackOut));

	function automatic sfo_out_t expOut(input logic [9:0] w, input logic g);
		return '{outEnable: g ? w[9:2] : 8'h00,
			outTypeSel: {{6{w[1]}}, {2{w[0]}}}};
	endfunction

	task automatic test_done();
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, s);
		tests_run++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", nm, e, s);
			failures++;
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		busReq <= '{read: !wr, write: wr, address: a, writedata: d,
			byteenable: 4'hf};
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		busReq <= '0;
		if (n >= 50) begin
			failures++;
			test_done();
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		// Link side needs serial edges while reset is low
		repeat (3) sfo_host_model_inst.pulse(1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		globalOutEnable <= 1'b1;
		// Link reset leaves through two serial flops: flush it with zeros
		repeat (2) sfo_host_model_inst.pulse(1'b0);
		settle(8);
		chk("startup", expOut(10'h000, 1'b0), outCtl);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h1, q);
		for (int k = 0; k < 5; k++) begin
			sfo_host_model_inst.shift(words[k], rb);
			chk("readback", act, rb);
			chk("held", expOut(act, 1'b1), outCtl);
			sfo_host_model_inst.latch();
			settle(10);
			act = words[k];
			chk("outctl", expOut(act, 1'b1), outCtl);
			bus(1'b0, 4'h8, 32'h0);
			chk("config", {22'h0, act}, q);
		end
		globalOutEnable <= 1'b0;
		settle(8);
		chk("oe low", expOut(act, 1'b0), outCtl);
		bus(1'b0, 4'hc, 32'h0);
		chk("outstat", {16'h0, {{6{act[1]}}, {2{act[0]}}}, 8'h00}, q);
		globalOutEnable <= 1'b1;
		settle(8);
		chk("oe high", expOut(act, 1'b1), outCtl);
		bus(1'b1, 4'h0, 32'h0);
		settle(8);
		chk("soft off", expOut(act, 1'b0), outCtl);
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b1, 4'h8, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk("config ro", {22'h0, act}, q);
		bus(1'b0, 4'h4, 32'h0);
		chk("status", 32'h7, q);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		test_done();
	end

	initial begin
		#200000;
		failures++;
		test_done();
	end
endmodule
